//--- src/apufcm_top.sv
// instruction sequencer for coprocessor loads with update and user-defined ops
`timescale 1ns/1ps
`include "apufcm_defines.svh"
module apufcm_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // decoded instruction
  input wire logic ins_valid,
  output logic ins_ready,
  input wire apufcm_pkg::apufcm_op_t ins_op,
  input wire logic [3:0] ins_udi_num,
  input wire logic ins_rcn,
  input wire logic [4:0] ins_t,
  input wire logic [4:0] ins_a,
  input wire logic [4:0] ins_b,
  input wire logic ins_rsvd_nonzero,
  input wire logic [31:0] base_gpr,
  input wire logic [31:0] index_gpr,
  // translation and protection state
  input wire logic data_reloc_en,
  input wire logic user_mode,
  input wire logic tlb_hit,
  input wire logic zone_no_access,
  // memory read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // base register write back
  output logic gpr_wr_en,
  output logic [4:0] gpr_wr_idx,
  output logic [31:0] gpr_wr_data,
  // exceptions
  output logic exc_data_storage,
  output logic exc_tlb_miss,
  // coprocessor port
  output logic cop_valid,
  input wire logic cop_ready,
  output apufcm_pkg::apufcm_op_t cop_op,
  output logic [4:0] coproc_target_imm,
  output logic [4:0] cop_src_a,
  output logic [4:0] cop_src_b,
  output logic [3:0] cop_udi_num,
  output logic cop_cr_update,
  output logic [1:0] cop_word_idx,
  output logic [31:0] cop_data
);
  import apufcm_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SEND, ST_WB} apufcm_state_t;

  apufcm_state_t state_r;
  logic [31:0] effective_address_r;
  logic [4:0] base_idx_r;
  logic [1:0] word_cnt_r;
  logic [1:0] last_word_r;
  logic [31:0] effective_address_nxt;
  logic tlb_fault;
  logic zone_fault;
  apufcm_lane_if lif ();

  apufcm_lane u_lane (
    .lif(lif)
  );

  assign effective_address_nxt = base_gpr + index_gpr;
  assign ins_ready = (state_r == ST_IDLE);
  assign tlb_fault = data_reloc_en && !tlb_hit;
  assign zone_fault = data_reloc_en && user_mode && zone_no_access;
  assign lif.mem_word = mem_rdata;
  assign lif.lane = effective_address_r[1:0];
  assign lif.op = cop_op;

  // instruction sequencing; invalid forms run as ordinary loads
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      word_cnt_r <= 2'h0;
      last_word_r <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          word_cnt_r <= 2'h0;
          if (ins_valid) begin
            if (ins_op == APUFCM_OP_UDI) begin
              state_r <= ST_SEND;
            end else begin
              state_r <= ST_FETCH;
            end
            case (ins_op)
              APUFCM_OP_DOUBLE: last_word_r <= `APUFCM_WORDS_DOUBLE;
              APUFCM_OP_QUAD: last_word_r <= `APUFCM_WORDS_QUAD;
              default: last_word_r <= `APUFCM_WORDS_ONE;
            endcase
          end
        end
        ST_FETCH: begin
          if (tlb_fault || zone_fault) begin
            state_r <= ST_IDLE;
          end else if (mem_ack) begin
            state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          // next word only after the coprocessor took this one
          if (cop_ready) begin
            if (cop_op == APUFCM_OP_UDI) begin
              state_r <= ST_IDLE;
            end else if (word_cnt_r == last_word_r) begin
              state_r <= ST_WB;
            end else begin
              word_cnt_r <= word_cnt_r + 2'h1;
              state_r <= ST_FETCH;
            end
          end
        end
        ST_WB: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // instruction fields held for the whole sequence
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cop_op <= APUFCM_OP_UDI;
      coproc_target_imm <= 5'h00;
      cop_src_a <= 5'h00;
      cop_src_b <= 5'h00;
      cop_udi_num <= 4'h0;
      cop_cr_update <= 1'b0;
      base_idx_r <= 5'h00;
      effective_address_r <= 32'h0000_0000;
    end else if (state_r == ST_IDLE && ins_valid) begin
      cop_op <= ins_op;
      coproc_target_imm <= ins_t;
      cop_src_a <= ins_a;
      cop_src_b <= ins_b;
      cop_udi_num <= ins_udi_num;
      cop_cr_update <= (ins_op == APUFCM_OP_UDI) && !ins_rcn;
      base_idx_r <= ins_a;
      effective_address_r <= effective_address_nxt;
    end
  end

  // memory request, word address steps by four from the aligned address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
    end else if (state_r == ST_IDLE && ins_valid && ins_op != APUFCM_OP_UDI) begin
      mem_req <= 1'b1;
      mem_addr <= effective_address_nxt & `APUFCM_ALIGN_MASK;
    end else if (state_r == ST_FETCH && (tlb_fault || zone_fault || mem_ack)) begin
      mem_req <= 1'b0;
    end else if (state_r == ST_SEND && cop_ready && cop_op != APUFCM_OP_UDI
                 && word_cnt_r != last_word_r) begin
      mem_req <= 1'b1;
      mem_addr <= mem_addr + `APUFCM_WORD_STEP;
    end
  end

  // coprocessor data word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cop_valid <= 1'b0;
      cop_data <= 32'h0000_0000;
      cop_word_idx <= 2'h0;
    end else if (state_r == ST_IDLE && ins_valid && ins_op == APUFCM_OP_UDI) begin
      cop_valid <= 1'b1;
      cop_data <= 32'h0000_0000;
      cop_word_idx <= 2'h0;
    end else if (state_r == ST_FETCH && !tlb_fault && !zone_fault && mem_ack) begin
      cop_valid <= 1'b1;
      cop_data <= lif.result;
      cop_word_idx <= word_cnt_r;
    end else if (state_r == ST_SEND && cop_ready) begin
      cop_valid <= 1'b0;
    end
  end

  // exceptions abort the instruction before any register is altered
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      exc_tlb_miss <= 1'b0;
      exc_data_storage <= 1'b0;
    end else begin
      exc_tlb_miss <= (state_r == ST_FETCH) && tlb_fault;
      exc_data_storage <= (state_r == ST_FETCH) && !tlb_fault && zone_fault;
    end
  end

  // base register update after the last word
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gpr_wr_en <= 1'b0;
      gpr_wr_idx <= 5'h00;
      gpr_wr_data <= 32'h0000_0000;
    end else begin
      gpr_wr_en <= (state_r == ST_SEND) && cop_ready && cop_op != APUFCM_OP_UDI
                   && word_cnt_r == last_word_r;
      gpr_wr_idx <= base_idx_r;
      gpr_wr_data <= effective_address_r;
    end
  end
endmodule

//--- src/apufcm_defines.svh
// constants for the coprocessor load-with-update and user-defined instruction port
// What this block does
// - coprocessor target immediate is five bits, passed through unchanged.
// - sixteen user-defined instructions, each with and without condition update.
// - selector 0 means condition-modifying form, 1 means non-modifying form.
// - user-defined instructions carry three five-bit operand fields.
// - effective address is base plus index, base never replaced by zero.
// - words fetched at address with low two bits cleared; lane from low bits.
// - byte load delivers the addressed byte sign-extended to 32 bits.
// - halfword load delivers the addressed halfword sign-extended to 32 bits.
// - word load delivers the aligned word unmodified.
// - double load sends words at address and address plus four.
// - quad load sends four words at offsets zero, four, eight, twelve.
// - every load that raises no exception writes the effective address back into the base register.
// - data-storage exception on no-access zone in user mode with relocation.
// - translation-miss exception when relocation on and no valid entry matches.
// - reserved bits set or base field zero: undefined result, no program exception.
`ifndef APUFCM_DEFINES_SVH
`define APUFCM_DEFINES_SVH
`define APUFCM_WORD_STEP 32'h0000_0004
`define APUFCM_ALIGN_MASK 32'hFFFF_FFFC
`define APUFCM_WORDS_DOUBLE 2'h1
`define APUFCM_WORDS_QUAD 2'h3
`define APUFCM_WORDS_ONE 2'h0
`endif

//--- src/apufcm_pkg.sv
// types shared by the coprocessor port modules
package apufcm_pkg;
  typedef enum logic [2:0] {
    APUFCM_OP_UDI,
    APUFCM_OP_BYTE,
    APUFCM_OP_HALF,
    APUFCM_OP_WORD,
    APUFCM_OP_DOUBLE,
    APUFCM_OP_QUAD
  } apufcm_op_t;
endpackage

//--- src/apufcm_lane_if.sv
// carrier between the sequencer and the lane extractor
`timescale 1ns/1ps
interface apufcm_lane_if;
  import apufcm_pkg::*;
  logic [31:0] mem_word;
  logic [1:0] lane;
  apufcm_op_t op;
  logic [31:0] result;
  modport seq (output mem_word, output lane, output op, input result);
  modport ext (input mem_word, input lane, input op, output result);
endinterface

//--- src/apufcm_lane.sv
// byte and halfword lane selection with sign extension
`timescale 1ns/1ps
module apufcm_lane (
  apufcm_lane_if.ext lif
);
  import apufcm_pkg::*;
  logic [7:0] byte_sel;
  logic [15:0] half_sel;
  always_comb begin
    // big-endian lanes: lane 0 is the most significant byte
    case (lif.lane)
      2'h0: byte_sel = lif.mem_word[31:24];
      2'h1: byte_sel = lif.mem_word[23:16];
      2'h2: byte_sel = lif.mem_word[15:8];
      default: byte_sel = lif.mem_word[7:0];
    endcase
    half_sel = lif.lane[1] ? lif.mem_word[15:0] : lif.mem_word[31:16];
    case (lif.op)
      APUFCM_OP_BYTE: lif.result = {{24{byte_sel[7]}}, byte_sel};
      APUFCM_OP_HALF: lif.result = {{16{half_sel[15]}}, half_sel};
      default: lif.result = lif.mem_word;
    endcase
  end
endmodule

//--- tb/apufcm_monitor.sv
// concurrent checks on the coprocessor load port
`timescale 1ns/1ps
module apufcm_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // instruction
  input wire logic ins_valid,
  input wire logic ins_ready,
  input wire apufcm_pkg::apufcm_op_t ins_op,
  input wire logic ins_rcn,
  input wire logic [31:0] base_gpr,
  input wire logic [31:0] index_gpr,
  input wire logic data_reloc_en,
  input wire logic tlb_hit,
  // memory, write back, fault
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic gpr_wr_en,
  input wire logic exc_tlb_miss,
  // coprocessor
  input wire logic cop_valid,
  input wire logic cop_ready,
  input wire logic [31:0] cop_data,
  input wire logic cop_cr_update
);
  import apufcm_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire take = ins_valid && ins_ready;
  AST_EA: assert property (take && ins_op != APUFCM_OP_UDI && !data_reloc_en
    |=> mem_req && mem_addr == (($past(base_gpr) + $past(index_gpr)) & 32'hFFFF_FFFC))
    else $error("first fetch address wrong");
  AST_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  AST_UDI: assert property (take && ins_op == APUFCM_OP_UDI
    |=> cop_valid && cop_cr_update == !$past(ins_rcn)) else $error("user op not passed on");
  AST_ACK: assert property (mem_req && mem_ack |=> cop_valid && !mem_req)
    else $error("fetched word not offered");
  AST_HOLD: assert property (cop_valid && !cop_ready |=> cop_valid && $stable(cop_data))
    else $error("offered word dropped or changed");
  AST_WB: assert property (gpr_wr_en |-> $past(cop_valid && cop_ready))
    else $error("base write without last handshake");
  AST_TLB: assert property (exc_tlb_miss |-> $past(data_reloc_en) && !$past(tlb_hit))
    else $error("translation miss without cause");
  AST_BUSY: assert property (take |=> !ins_ready)
    else $error("second instruction accepted while busy");
endmodule

//--- tb/apufcm_cop_model.sv
// behavioural coprocessor that accepts words after a set stall
`timescale 1ns/1ps
module apufcm_cop_model (
  // clock
  input wire logic clk_sys,
  // offered word
  input wire logic cop_valid,
  input wire logic [31:0] cop_data,
  input wire logic [1:0] cop_word_idx,
  input wire logic [1:0] stall,
  output logic cop_ready
);
  logic [1:0] wait_r = 2'h0;
  logic [31:0] wd [4];
  logic [1:0] wx [4];
  int cnt = 0;
  initial cop_ready = 1'b0;
  // any user op is accepted as it comes; its meaning is ours alone
  always @(posedge clk_sys) begin
    cop_ready <= cop_valid && !cop_ready && wait_r >= stall;
    wait_r <= (cop_valid && !cop_ready) ? wait_r + 2'h1 : 2'h0;
    if (cop_valid && cop_ready) begin
      wd[cnt % 4] <= cop_data;
      wx[cnt % 4] <= cop_word_idx;
      cnt <= cnt + 1;
    end
  end
endmodule

//--- tb/apufcm_top_bench.sv
// self-checking bench for the coprocessor load sequencer
`timescale 1ns/1ps
module apufcm_top_bench;
  import apufcm_pkg::*;
  logic clk_sys = 0, rstn = 0, ins_valid = 0, ins_rcn = 0, ins_rsvd_nonzero = 0;
  logic data_reloc_en = 0, user_mode = 1, tlb_hit = 1, zone_no_access = 0, mem_ack = 0;
  logic ins_ready, mem_req, gpr_wr_en, exc_data_storage, exc_tlb_miss, cop_valid, cop_ready;
  logic cop_cr_update;
  apufcm_op_t ins_op = APUFCM_OP_UDI;
  apufcm_op_t cop_op;
  logic [3:0] ins_udi_num = 0;
  logic [3:0] cop_udi_num;
  logic [4:0] ins_t = 0, ins_a = 0, ins_b = 0, gpr_wr_idx, coproc_target_imm, cop_src_a, cop_src_b;
  logic [31:0] base_gpr = 0, index_gpr = 0, mem_rdata = 0, mem_addr, gpr_wr_data, cop_data;
  logic [1:0] cop_word_idx, stall = 0;
  int mismatches = 0, checks = 0;
  always #10 clk_sys = ~clk_sys;
  apufcm_top i_apufcm_top (.*);
  apufcm_cop_model i_apufcm_cop_model (.clk_sys(clk_sys), .cop_valid(cop_valid),
    .cop_data(cop_data), .cop_word_idx(cop_word_idx), .stall(stall), .cop_ready(cop_ready));
  function logic [31:0] mf(input logic [31:0] a);
    return a ^ 32'h80F1_7F0E;
  endfunction
  // memory answers one cycle after a request unless relocation is on, then never; data is scrambled outside the ack
  always @(negedge clk_sys) begin
    mem_ack <= mem_req && !mem_ack && !data_reloc_en;
    mem_rdata <= (mem_req && !mem_ack) ? mf(mem_addr) : ~mem_rdata;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task stop_test;
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task go(input apufcm_op_t op, input logic [4:0] a, input logic [31:0] b, input logic [31:0] x,
    input int fk);
    int n, n0, nw;
    logic [31:0] ea, e;
    @(negedge clk_sys);
    ins_valid = 1;
    ins_op = op;
    ins_a = a;
    ins_t = ~a;
    ins_b = a + 5'h1;
    base_gpr = b;
    index_gpr = x;
    data_reloc_en = fk != 0;
    tlb_hit = fk != 1;
    zone_no_access = fk == 2;
    ins_rsvd_nonzero = a == 5'h0;
    n0 = i_apufcm_cop_model.cnt;
    @(negedge clk_sys);
    ins_valid = 0;
    n = 0;
    while (n < 40 && !(gpr_wr_en || exc_tlb_miss || exc_data_storage ||
      (op == APUFCM_OP_UDI && cop_valid && cop_ready))) begin
      @(negedge clk_sys);
      n++;
    end
    ea = b + x;
    nw = op == APUFCM_OP_QUAD ? 4 : op == APUFCM_OP_DOUBLE ? 2 : 1;
    check("op", 32'(cop_op), 32'(op));
    if (op == APUFCM_OP_UDI) begin
      check("udi_num", 32'(cop_udi_num), 32'(ins_udi_num));
      check("cr_update", 32'(cop_cr_update), 32'(!ins_rcn));
      check("fields", {cop_src_a, cop_src_b, coproc_target_imm}, {a, a + 5'h1, ~a});
    end else if (fk != 0) begin
      check("fault", {exc_tlb_miss, exc_data_storage, gpr_wr_en}, fk == 1 ? 3'h4 : 3'h2);
      check("aborted", 32'(i_apufcm_cop_model.cnt - n0), 0);
    end else begin
      check("base_wb", gpr_wr_data, ea);
      check("base_idx", 32'(gpr_wr_idx), 32'(a));
      check("words", 32'(i_apufcm_cop_model.cnt - n0), 32'(nw));
      for (int i = 0; i < nw; i++) begin
        e = mf((ea & 32'hFFFF_FFFC) + 32'(4 * i));
        if (op == APUFCM_OP_BYTE) e = {{24{e[31 - 8 * ea[1:0]]}}, e[31 - 8 * ea[1:0] -: 8]};
        if (op == APUFCM_OP_HALF) e = {{16{e[31 - 16 * ea[1]]}}, e[31 - 16 * ea[1] -: 16]};
        check("data", i_apufcm_cop_model.wd[(n0 + i) % 4], e);
        check("word_idx", 32'(i_apufcm_cop_model.wx[(n0 + i) % 4]), 32'(i));
      end
    end
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rstn = 1;
    for (int k = 0; k < 16; k++) begin
      ins_udi_num = 4'(k);
      ins_rcn = k[0];
      go(APUFCM_OP_UDI, 5'(k), 32'h0, 32'h0, 0);
    end
    for (int k = 0; k < 4; k++) go(APUFCM_OP_BYTE, 5'h3, 32'h1000_0FFF, 32'(k + 1), 0);
    go(APUFCM_OP_HALF, 5'h4, 32'h1000_0FFF, 32'h3, 0);
    go(APUFCM_OP_HALF, 5'h4, 32'h1000_0FFF, 32'h1, 0);
    stall = 2'h2;
    go(APUFCM_OP_WORD, 5'h7, 32'hFFFF_FFF0, 32'h17, 0);
    go(APUFCM_OP_DOUBLE, 5'h8, 32'h0000_3FFE, 32'h7, 0);
    go(APUFCM_OP_QUAD, 5'h9, 32'h2000_0005, 32'h2, 0);
    stall = 2'h0;
    go(APUFCM_OP_QUAD, 5'h0, 32'h0000_0100, 32'h10, 0);
    go(APUFCM_OP_WORD, 5'h9, 32'h0000_0040, 32'h4, 1);
    go(APUFCM_OP_WORD, 5'h9, 32'h0000_0040, 32'h4, 2);
    go(APUFCM_OP_WORD, 5'h9, 32'h0000_0040, 32'h4, 0);
    stop_test;
  end
  initial begin
    #100000;
    mismatches++;
    stop_test;
  end
endmodule
bind apufcm_top apufcm_monitor i_apufcm_monitor (.clk_sys(clk_sys), .rstn(rstn),
  .ins_valid(ins_valid), .ins_ready(ins_ready), .ins_op(ins_op), .ins_rcn(ins_rcn),
  .base_gpr(base_gpr), .index_gpr(index_gpr), .data_reloc_en(data_reloc_en), .tlb_hit(tlb_hit),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .gpr_wr_en(gpr_wr_en),
  .exc_tlb_miss(exc_tlb_miss), .cop_valid(cop_valid), .cop_ready(cop_ready),
  .cop_data(cop_data), .cop_cr_update(cop_cr_update));
